//--- hdl/ccrd_pkg.sv
// Constants, types and register map of the card reader function decoder
//
// Overview of operation
// RQ1 - Processor opens each card operation with an initiate instruction naming reader channel.
// RQ2 - Software leaves function word bits 21 to 25 at zero.
// RQ3 - Bits 20,19: 01 stacker 1, 10 or 11 stacker 2, 00 stacker 0.
// RQ4 - Bit 18 one stores translated station-2 image, zero stores raw image.
// RQ5 - Bit 17 one feeds exactly one card, zero feeds none.
// RQ6 - Bit 16 one raises interrupt when the word enters the synchronizer.
// RQ7 - Software gives base in bits 15..1 with bits 1..6 zero.
// RQ8 - 80-column: translated image in L..L+19, raw image in L..L+39.
// RQ9 - 90-column: all card data in L..L+23.
// RQ10 - Cards without new word use area and translation of last executed word.
// RQ11 - No word given while a card is at station 4: stacker 0.
// RQ12 - Indicators at codes: initiation 2, data error 5, oversight 6, fault 7.
// RQ13 - Initiation set when a received word requests interrupt.
// RQ14 - Data error from station 2 card signalled at next card cycle start.
// RQ15 - Erroneous cards go to the stacker the program chose.
// RQ16 - On data error the standby word executes, then memory stays idle until cleared.
// RQ17 - Interrupt requested plus fetch error sets initiation and fault together.
// RQ18 - Data error when granted accesses per card differ from 480 or 288.
// RQ19 - Image words go to ascending addresses from base, one access per word.
`default_nettype none
package ccrd_pkg;
  localparam int FS_W   = 26;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 24;
  localparam int CNT_W  = 10;
  // Function word fields
  localparam int FS_STK_HI = 20;
  localparam int FS_STK_LO = 19;
  localparam int FS_XLATE  = 18;
  localparam int FS_FEED   = 17;
  localparam int FS_IRQ    = 16;
  localparam int FS_L_HI   = 15;
  localparam int FS_L_LO   = 1;
  // Indicator positions in the status register
  localparam int IND_INIT  = 2;
  localparam int IND_DERR  = 5;
  localparam int IND_OVS   = 6;
  localparam int IND_FAULT = 7;
  localparam int ST_STANDBY = 0;
  localparam logic [7:0] IND_MASK = 8'hE4;
  // Image sizes and access counts
  localparam logic [ADDR_W-1:0] WORDS_80_XL  = 15'h0014;
  localparam logic [ADDR_W-1:0] WORDS_80_RAW = 15'h0028;
  localparam logic [ADDR_W-1:0] WORDS_90     = 15'h0018;
  localparam logic [CNT_W-1:0]  ACC_80       = 10'h1E0;
  localparam logic [CNT_W-1:0]  ACC_90       = 10'h120;
  // Register byte offsets
  localparam logic [7:0] REG_STANDBY = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_MASK    = 8'h08;
  localparam logic [7:0] REG_CTRL    = 8'h0C;
  localparam logic [7:0] REG_ACTIVE  = 8'h10;
  localparam logic [7:0] REG_COUNT   = 8'h14;
  localparam int CTRL_COL90 = 0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] STK0 = 2'h0;
  localparam logic [1:0] STK1 = 2'h1;
  localparam logic [1:0] STK2 = 2'h2;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } ccrd_mem_wr_t;

  typedef struct packed {
    logic [DATA_W-1:0] raw;
    logic [DATA_W-1:0] xlat;
  } ccrd_img_t;
endpackage
`default_nettype wire

//--- hdl/ccrd_xfer_ctr.sv
// Access counter and word offset generator for one card image
`default_nettype none
module ccrd_xfer_ctr
  import ccrd_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Control
  input  wire logic              load,
  input  wire logic              gnt,
  input  wire logic [ADDR_W-1:0] limit,
  // Results
  output logic      [ADDR_W-1:0] offset_q,
  output logic      [CNT_W-1:0]  count_q
);
  logic [ADDR_W-1:0] offset_d;
  logic [CNT_W-1:0]  count_d;

  always_comb
  begin
    offset_d = offset_q;
    count_d  = count_q;
    if (load)
    begin
      offset_d = '0;
      count_d  = '0;
    end
    else if (gnt)
    begin
      count_d = count_q + 10'h001;
      // Ascending words, wrapping inside the image area
      if (offset_q + 15'h0001 >= limit) // RQ19
        offset_d = '0;
      else
        offset_d = offset_q + 15'h0001;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      offset_q <= '0;
      count_q  <= '0;
    end
    else
    begin
      offset_q <= offset_d;
      count_q  <= count_d;
    end
  end
endmodule
`default_nettype wire

//--- hdl/ccrd_top.sv
// Card reader function decoder with register slave and image transfer
`default_nettype none
module ccrd_top
  import ccrd_pkg::*;
(
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // Register bus
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic [1:0]                 s_axi_bresp,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  // Card feed mechanism
  input  wire logic                  cycle_start,
  input  wire logic                  card_end,
  input  wire logic                  st4_card,
  input  wire logic                  rd_valid,
  input  wire ccrd_pkg::ccrd_img_t   rd_img,
  input  wire logic                  hole_err,
  input  wire logic                  fs_fetch_err,
  input  wire logic                  fault_evt,
  input  wire logic                  oversight_evt,
  output logic                       feed_card,
  output logic                       stack_strobe,
  output logic [1:0]                 stack_sel,
  output logic                       xlate_sel,
  // Memory write port
  output logic                       mem_req,
  output ccrd_pkg::ccrd_mem_wr_t     mem_wr,
  input  wire logic                  mem_gnt,
  // Interrupt
  output logic                       irq
);
  import ccrd_pkg::*;

  function automatic logic [1:0] stk_decode(input logic [1:0] code);
    case (code)
      2'h1:    stk_decode = STK1;
      2'h2:    stk_decode = STK2;
      2'h3:    stk_decode = STK2;
      default: stk_decode = STK0;
    endcase
  endfunction

  function automatic logic [31:0] strobe(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
    for (int i = 0; i < 4; i++)
      strobe[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic               awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic               arready_q, arready_d, rvalid_q, rvalid_d;
  logic               aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0]         awaddr_q, awaddr_d;
  logic [31:0]        wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0]         wstrb_q, wstrb_d;
  logic [1:0]         bresp_q, bresp_d, rresp_q, rresp_d;
  logic [FS_W-1:0]    standby_fs_q, standby_fs_d, active_fs_q, active_fs_d;
  logic               standby_q, standby_d;
  logic [7:0]         status_q, status_d, mask_q, mask_d;
  logic               col90_q, col90_d;
  logic               xlate_q, xlate_d;
  logic [ADDR_W-1:0]  base_q, base_d;
  logic               derr_pend_q, derr_pend_d, ovr_q, ovr_d;
  logic               feed_q, feed_d, strobe_q, strobe_d, req_q, req_d, irq_q, irq_d;
  logic [1:0]         sel_q, sel_d;
  ccrd_mem_wr_t       wr_q, wr_d;
  logic               exec, inhibit, do_write;
  logic [7:0]         w1c, ind_set;
  logic [ADDR_W-1:0]  limit, offset;
  logic [CNT_W-1:0]   count, expected;

  assign exec     = cycle_start && standby_q;
  assign inhibit  = status_q[IND_DERR] || status_q[IND_FAULT];
  assign do_write = aw_have_q && w_have_q && !bvalid_q;
  assign limit    = col90_q ? WORDS_90 : (xlate_q ? WORDS_80_XL : WORDS_80_RAW); // RQ8 RQ9
  assign expected = col90_q ? ACC_90 : ACC_80;

  ccrd_xfer_ctr u_ctr (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .load     (cycle_start),
    .gnt      (req_q && mem_gnt),
    .limit    (limit),
    .offset_q (offset),
    .count_q  (count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register slave
  always_comb
  begin
    awready_d = !aw_have_q && !awready_q;
    wready_d  = !w_have_q && !wready_q;
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q && !s_axi_bready;
    bresp_d   = bresp_q;
    arready_d = !arready_q && !rvalid_q && s_axi_arvalid;
    rvalid_d  = rvalid_q && !s_axi_rready;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (s_axi_awvalid && awready_q)
    begin
      aw_have_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
      awready_d = 1'b0;
    end
    if (s_axi_wvalid && wready_q)
    begin
      w_have_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
      wready_d = 1'b0;
    end
    if (do_write)
    begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (awaddr_q == REG_STANDBY || awaddr_q == REG_STATUS ||
                   awaddr_q == REG_MASK || awaddr_q == REG_CTRL) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_axi_arvalid && arready_q)
    begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      case (s_axi_araddr)
        REG_STANDBY: rdata_d = {6'h00, standby_fs_q};
        REG_STATUS:  rdata_d = {24'h000000, status_q};
        REG_MASK:    rdata_d = {24'h000000, mask_q};
        REG_CTRL:    rdata_d = {31'h00000000, col90_q};
        REG_ACTIVE:  rdata_d = {6'h00, active_fs_q};
        REG_COUNT:   rdata_d = {22'h000000, count};
        default:
        begin
          rdata_d = 32'h00000000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Function decode, indicators and image transfer
  always_comb
  begin
    standby_fs_d = standby_fs_q;
    standby_d    = standby_q;
    mask_d       = mask_q;
    col90_d      = col90_q;
    w1c          = 8'h00;
    ind_set      = 8'h00;
    active_fs_d  = active_fs_q;
    xlate_d      = xlate_q;
    base_d       = base_q;
    derr_pend_d  = derr_pend_q;
    ovr_d        = ovr_q;
    feed_d       = 1'b0;
    strobe_d     = 1'b0;
    sel_d        = sel_q;
    req_d        = req_q && !mem_gnt;
    wr_d         = wr_q;
    if (do_write)
    begin
      case (awaddr_q)
        REG_STANDBY:
        begin
          standby_fs_d = FS_W'(strobe({6'h00, standby_fs_q}, wdata_q, wstrb_q));
          standby_d    = 1'b1;
        end
        REG_STATUS: w1c = wstrb_q[0] ? wdata_q[7:0] & IND_MASK : 8'h00;
        REG_MASK:   mask_d = wstrb_q[0] ? wdata_q[7:0] & IND_MASK : mask_q;
        REG_CTRL:   col90_d = wstrb_q[0] ? wdata_q[CTRL_COL90] : col90_q;
        default:    w1c = 8'h00;
      endcase
    end
    if (cycle_start)
    begin
      // Error on previous card is signalled as the new cycle opens
      if (derr_pend_q)
        ind_set[IND_DERR] = 1'b1; // RQ14
      derr_pend_d = 1'b0;
      ovr_d       = 1'b0;
      if (st4_card)
      begin
        strobe_d = 1'b1;
        // Stacker follows the executed word, errors included; stacker 0 when no word executes
        sel_d = exec ? stk_decode(standby_fs_q[FS_STK_HI:FS_STK_LO]) : STK0; // RQ3 RQ11 RQ15
      end
    end
    if (exec)
    begin
      // Standby word executes even on the data error interrupt
      active_fs_d = standby_fs_q; // RQ16
      standby_d   = do_write && (awaddr_q == REG_STANDBY);
      feed_d      = standby_fs_q[FS_FEED]; // RQ5
      xlate_d     = standby_fs_q[FS_XLATE]; // RQ4 RQ10
      base_d      = standby_fs_q[FS_L_HI:FS_L_LO]; // RQ7 RQ10
      if (standby_fs_q[FS_IRQ])
        ind_set[IND_INIT] = 1'b1; // RQ6 RQ13 RQ17
      if (fs_fetch_err)
        ind_set[IND_FAULT] = 1'b1; // RQ17
    end
    if (card_end && (count != expected || hole_err || ovr_q))
      derr_pend_d = 1'b1; // RQ18
    if (fault_evt)
      ind_set[IND_FAULT] = 1'b1; // RQ12
    if (oversight_evt)
      ind_set[IND_OVS] = 1'b1; // RQ12
    if (rd_valid)
    begin
      if (req_q && !mem_gnt)
        ovr_d = 1'b1;
      else if (!inhibit)
      begin
        // One access per word, placed at base plus running offset
        req_d   = 1'b1; // RQ19
        wr_d.addr = base_q + offset;
        wr_d.data = xlate_q ? rd_img.xlat : rd_img.raw; // RQ4
      end
    end
    // Hardware set wins over a software clear
    status_d = (status_q & ~w1c) | ind_set;
    irq_d    = |(status_d & mask_q);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q    <= 1'b0;
      wready_q     <= 1'b0;
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      awaddr_q     <= 8'h00;
      wdata_q      <= 32'h00000000;
      wstrb_q      <= 4'h0;
      bvalid_q     <= 1'b0;
      bresp_q      <= RESP_OKAY;
      arready_q    <= 1'b0;
      rvalid_q     <= 1'b0;
      rdata_q      <= 32'h00000000;
      rresp_q      <= RESP_OKAY;
      standby_fs_q <= '0;
      standby_q    <= 1'b0;
      active_fs_q  <= '0;
      status_q     <= 8'h00;
      mask_q       <= 8'h00;
      col90_q      <= 1'b0;
      xlate_q      <= 1'b0;
      base_q       <= '0;
      derr_pend_q  <= 1'b0;
      ovr_q        <= 1'b0;
      feed_q       <= 1'b0;
      strobe_q     <= 1'b0;
      sel_q        <= STK0;
      req_q        <= 1'b0;
      wr_q         <= '0;
      irq_q        <= 1'b0;
    end
    else
    begin
      awready_q    <= awready_d;
      wready_q     <= wready_d;
      aw_have_q    <= aw_have_d;
      w_have_q     <= w_have_d;
      awaddr_q     <= awaddr_d;
      wdata_q      <= wdata_d;
      wstrb_q      <= wstrb_d;
      bvalid_q     <= bvalid_d;
      bresp_q      <= bresp_d;
      arready_q    <= arready_d;
      rvalid_q     <= rvalid_d;
      rdata_q      <= rdata_d;
      rresp_q      <= rresp_d;
      standby_fs_q <= standby_fs_d;
      standby_q    <= standby_d;
      active_fs_q  <= active_fs_d;
      status_q     <= status_d;
      mask_q       <= mask_d;
      col90_q      <= col90_d;
      xlate_q      <= xlate_d;
      base_q       <= base_d;
      derr_pend_q  <= derr_pend_d;
      ovr_q        <= ovr_d;
      feed_q       <= feed_d;
      strobe_q     <= strobe_d;
      sel_q        <= sel_d;
      req_q        <= req_d;
      wr_q         <= wr_d;
      irq_q        <= irq_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign feed_card     = feed_q;
  assign stack_strobe  = strobe_q;
  assign stack_sel     = sel_q;
  assign xlate_sel     = xlate_q;
  assign mem_req       = req_q;
  assign mem_wr        = wr_q;
  assign irq           = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  init_set_a: assert property (exec && standby_fs_q[FS_IRQ] |=> status_q[IND_INIT]) // RQ13
    else $error("initiation indicator not set");
  feed_pulse_a: assert property (exec |=> feed_card == $past(standby_fs_q[FS_FEED])) // RQ5
    else $error("feed pulse does not follow bit 17");
  stack_dec_a: assert property (exec && st4_card |=> stack_strobe && // RQ3
      stack_sel == stk_decode($past(standby_fs_q[FS_STK_HI:FS_STK_LO])))
    else $error("wrong stacker decode");
  stack_zero_a: assert property (cycle_start && !standby_q && st4_card // RQ11
      |=> stack_strobe && stack_sel == STK0)
    else $error("card without word not sent to stacker 0");
  both_ind_a: assert property (exec && fs_fetch_err && standby_fs_q[FS_IRQ] // RQ17
      |=> status_q[IND_INIT] && status_q[IND_FAULT])
    else $error("fetch error with interrupt must set both indicators");
  derr_next_a: assert property (cycle_start && derr_pend_q |=> status_q[IND_DERR]) // RQ14
    else $error("data error not raised at next cycle start");
  count_err_a: assert property (card_end && !cycle_start && // RQ18
      (count != expected || hole_err) |=> derr_pend_q)
    else $error("access count mismatch not flagged");
  inhibit_a: assert property (status_q[IND_DERR] && !mem_req |=> !mem_req) // RQ16
    else $error("memory access while data error is set");
  xlate_keep_a: assert property (!exec |=> $stable(xlate_sel)) // RQ10
    else $error("translation choice changed without a new word");
  addr_range_a: assert property (mem_req |-> (mem_wr.addr - base_q) < limit) // RQ8
    else $error("image word outside its area");
endmodule
`default_nettype wire

//--- testbench/ccrd_mem_model.sv
// Memory grant model for the card image write port
`default_nettype none
module ccrd_mem_model (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Memory handshake
  input  wire logic mem_req,
  output var  logic mem_gnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] wait_q;
  // Grants each request once, after 0 to 2 idle cycles
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mem_gnt <= 1'b0;
      wait_q  <= 2'h0;
    end
    else if (mem_req && !mem_gnt && wait_q == 2'h0)
      mem_gnt <= 1'b1;
    else if (mem_req && !mem_gnt)
      wait_q <= wait_q - 2'h1;
    else
    begin
      mem_gnt <= 1'b0;
      wait_q  <= 2'($urandom_range(2, 0));
    end
  end
endmodule
`default_nettype wire

//--- testbench/ccrd_tb_top.sv
// Self-checking bench for the card reader function decoder
`default_nettype none
module ccrd_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ccrd_pkg::*;
  `define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin failures++; \
    $display("ERROR %0t: %s", $time, m); end end
  logic              aclk = 0, aresetn = 0;
  logic              s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic              s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0]        s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0]        s_axi_awprot = 0, s_axi_arprot = 0;
  logic [31:0]       s_axi_wdata = 0, s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp, stack_sel;
  logic              cycle_start = 0, card_end = 0, st4_card = 0, rd_valid = 0, hole_err = 0;
  logic              fs_fetch_err = 0, fault_evt = 0, oversight_evt = 0;
  ccrd_img_t         rd_img = '0;
  logic              feed_card, stack_strobe, xlate_sel, mem_req, mem_gnt, irq;
  ccrd_mem_wr_t      mem_wr;
  int                failures = 0, n_checks = 0, n_feed = 0, off = 0;
  ccrd_mem_wr_t      exp_mem[$];
  logic [1:0]        exp_stk[$];
  logic [ADDR_W-1:0] base = '0;
  logic              xl = 0, col90 = 0;

  ccrd_top DUT (.*);
  ccrd_mem_model MEM (.aclk, .aresetn, .mem_req, .mem_gnt);

  always #2 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////////
  // Output watcher
  always @(posedge aclk)
  begin
    if (mem_req === 1'b1 && mem_gnt === 1'b1)
    begin
      `CHK(exp_mem.size() != 0, 1'b1, "unexpected memory write")
      if (exp_mem.size() != 0) `CHK(mem_wr, exp_mem.pop_front(), "memory write")
    end
    if (stack_strobe === 1'b1)
    begin
      `CHK(exp_stk.size() != 0, 1'b1, "unexpected stacking")
      if (exp_stk.size() != 0) `CHK(stack_sel, exp_stk.pop_front(), "stacker")
    end
    if (feed_card === 1'b1) n_feed++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Drivers
  task automatic clk(int n);
    repeat (n) @(posedge aclk);
  endtask

  // One-cycle strobe: 0 rd_valid, 1 cycle_start, 2 card_end, 3 oversight, 4 fault
  task automatic pulse(int k);
    {fault_evt, oversight_evt, card_end, cycle_start, rd_valid} <= 5'h01 << k;
    @(posedge aclk);
    {fault_evt, oversight_evt, card_end, cycle_start, rd_valid} <= 5'h00;
  endtask

  task automatic axw(logic [7:0] a, logic [31:0] d, logic [1:0] r);
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      if (!ad && s_axi_awvalid && s_axi_awready === 1'b1)
      begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wvalid && s_axi_wready === 1'b1)
      begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, r, "write response")
  endtask

  task automatic axr(logic [7:0] a, logic [31:0] d, logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, d, "read data")
    `CHK(s_axi_rresp, r, "read response")
  endtask

  // One station-2 word; ok low means memory must stay idle
  task automatic word(logic ok);
    ccrd_img_t v;
    v.raw  = 24'($urandom);
    v.xlat = 24'($urandom);
    rd_img <= v;
    if (ok) exp_mem.push_back({15'(base + off), xl ? v.xlat : v.raw});
    if (ok) off = (off + 1) % int'(col90 ? WORDS_90 : xl ? WORDS_80_XL : WORDS_80_RAW);
    pulse(0);
    if (ok) do @(posedge aclk); while (mem_req !== 1'b0);
    else
    begin
      clk(4);
      `CHK(mem_req, 1'b0, "access while inhibited")
    end
  endtask

  task automatic words(int n);
    repeat (n) word(1'b1);
    pulse(2);
  endtask

  // Optional standby word, then one card cycle start
  task automatic start(logic [25:0] w, logic pend);
    int nf;
    nf = n_feed;
    if (pend)
    begin
      axw(REG_STANDBY, {6'h00, w}, RESP_OKAY);
      base = w[15:1];
      xl = w[18];
    end
    off = 0;
    if (st4_card) exp_stk.push_back(!pend ? STK0 : w[20] ? STK2 : w[19] ? STK1 : STK0);
    @(posedge aclk);
    pulse(1);
    clk(2);
    `CHK(n_feed, nf + int'(pend & w[17]), "feed count")
    `CHK(xlate_sel, xl, "translate select")
  endtask

  task automatic summarize;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    #320us;
    failures++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Tests
  initial
  begin
    logic [25:0] w;
    void'($urandom(93733));
    clk(10);
    aresetn <= 1'b1;
    st4_card <= 1'b1;
    axr(REG_STATUS, 32'h0, RESP_OKAY);
    axr(8'h18, 32'h0, RESP_SLVERR);
    axw(REG_COUNT, 32'h1, RESP_SLVERR);
    axw(REG_MASK, 32'hE4, RESP_OKAY);
    axr(REG_MASK, 32'hE4, RESP_OKAY);
    $display("done: registers");
    for (int c = 0; c < 16; c++)
    begin
      w = {5'h00, c[3:0], 1'($urandom), 9'($urandom), 7'h00};
      start(w, 1'b1);
      axr(REG_ACTIVE, {6'h00, w}, RESP_OKAY);
      axr(REG_STATUS, {29'h0, w[16], 2'h0}, RESP_OKAY);
      `CHK(irq, w[16], "interrupt level")
      axw(REG_STATUS, 32'hE4, RESP_OKAY);
      clk(2);
      `CHK(irq, 1'b0, "interrupt cleared")
      words(int'(ACC_80));
    end
    $display("done: function codes");
    start(26'h0, 1'b0);
    words(int'(ACC_80));
    $display("done: no new word");
    start({5'h00, 4'h5, 1'b0, 9'h1A5, 7'h00}, 1'b1);
    words(5);
    w = {5'h00, 4'hB, 1'b0, 9'h0C3, 7'h00};
    start(w, 1'b1);
    axr(REG_STATUS, 32'h20, RESP_OKAY);
    axr(REG_ACTIVE, {6'h00, w}, RESP_OKAY);
    word(1'b0);
    axw(REG_STATUS, 32'h20, RESP_OKAY);
    words(int'(ACC_80));
    $display("done: data error");
    st4_card <= 1'b0;
    fs_fetch_err <= 1'b1;
    start({5'h00, 2'h0, xl, 1'b0, 1'b1, 16'h0000}, 1'b1);
    fs_fetch_err <= 1'b0;
    pulse(3);
    clk(1);
    axr(REG_STATUS, 32'hC4, RESP_OKAY);
    axw(REG_STATUS, 32'hE4, RESP_OKAY);
    pulse(4);
    clk(1);
    axr(REG_STATUS, 32'h80, RESP_OKAY);
    axw(REG_STATUS, 32'hE4, RESP_OKAY);
    st4_card <= 1'b1;
    $display("done: indicators");
    axw(REG_CTRL, 32'h1, RESP_OKAY);
    col90 = 1;
    for (int x = 0; x < 2; x++)
    begin
      start({5'h00, 2'h0, x[0], 2'h2, 9'($urandom), 7'h00}, 1'b1);
      hole_err <= x[0];
      words(int'(ACC_90));
      hole_err <= 1'b0;
    end
    start(26'h0, 1'b0);
    axr(REG_STATUS, 32'h20, RESP_OKAY);
    clk(4);
    `CHK(exp_mem.size(), 0, "writes missing")
    `CHK(exp_stk.size(), 0, "stacking missing")
    $display("done: 90 column");
    summarize();
  end
endmodule
`default_nettype wire
